// ---- logic/lcdcs_top.v ----
// Purpose: cascade support of a segment display driver: device index,
//          split acknowledge, frame alignment line and clock source
// Assumes: 25 MHz sys_clk; internal oscillator arrives as a tick pulse
// Notes: open-drain pins are split into value and enable outputs
`include "lcdcs_regs.vh"

module lcdcs_top (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    // strap and configuration pins
    input wire subaddr_pin_lo,
    input wire subaddr_pin_hi,
    input wire osc_sel_pin,
    // programmable address bit and command-side controls
    input wire group_select_bit,
    input wire [`LCDCS_IDX_W-1:0] addressed_index,
    input wire display_en,
    input wire [1:0] mux_mode,
    input wire ack_req,
    input wire int_osc_tick,
    // clock pin
    input wire clk_pin_in,
    output wire clk_pin_out,
    output wire clk_pin_oe,
    // frame alignment line
    input wire frame_sync_in,
    output wire frame_sync_out,
    output wire frame_sync_oe,
    // acknowledge line
    output wire ack_out_line_out,
    output wire ack_out_line_oe,
    // status
    output wire [`LCDCS_IDX_W-1:0] device_index,
    output wire dev_selected,
    output wire [`LCDCS_PHASE_W-1:0] bp_phase,
    output wire phase_tick,
    output wire realign_pulse
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // index of the last active backplane for a multiplex mode
    function [`LCDCS_PHASE_W-1:0] last_phase;
        input [1:0] mode;
        begin
            case (mode)
                `LCDCS_MUX_STATIC: last_phase = 2'h0;
                `LCDCS_MUX_2BP: last_phase = 2'h1;
                `LCDCS_MUX_3BP: last_phase = 2'h2;
                default: last_phase = 2'h3;
            endcase
        end
    endfunction

    localparam [`LCDCS_CNT_W-1:0] SYNC_LOW_CYC = `LCDCS_SYNC_LOW_CYC;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [`LCDCS_SYNC_LANES-1:0] pins_raw;
    wire [`LCDCS_SYNC_LANES-1:0] pins_sync;

    assign pins_raw[`LCDCS_LANE_A0] = subaddr_pin_lo;
    assign pins_raw[`LCDCS_LANE_A1] = subaddr_pin_hi;
    assign pins_raw[`LCDCS_LANE_OSC] = osc_sel_pin;
    assign pins_raw[`LCDCS_LANE_CLK] = clk_pin_in;
    assign pins_raw[`LCDCS_LANE_SYNC] = frame_sync_in;

    lcdcs_sync2 #(
        .WIDTH(`LCDCS_SYNC_LANES),
        .RST_VAL(`LCDCS_SYNC_RST_VAL)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    wire a0_s = pins_sync[`LCDCS_LANE_A0];
    wire a1_s = pins_sync[`LCDCS_LANE_A1];
    wire osc_ext_s = pins_sync[`LCDCS_LANE_OSC];
    wire clk_in_s = pins_sync[`LCDCS_LANE_CLK];
    wire sync_line_s = pins_sync[`LCDCS_LANE_SYNC];

    // ------------------------------------------------------------
    // device index and acknowledge
    // ------------------------------------------------------------
    reg [`LCDCS_IDX_W-1:0] device_index_reg;
    reg dev_selected_reg;
    reg ack_oe_reg;
    wire [`LCDCS_IDX_W-1:0] device_index_next = {group_select_bit, a1_s, a0_s};

    always @(posedge sys_clk) begin
        if (rst) begin
            device_index_reg <= `LCDCS_IDX_RST;
            dev_selected_reg <= 1'b0;
            ack_oe_reg <= 1'b0;
        end else if (clk_en) begin
            device_index_reg <= device_index_next;
            dev_selected_reg <= (addressed_index == device_index_next);
            // acknowledge has its own open-drain output, never the data input
            ack_oe_reg <= ack_req;
        end
    end

    // ------------------------------------------------------------
    // clock source
    // ------------------------------------------------------------
    reg clk_out_reg;
    reg clk_oe_reg;
    reg clk_in_d_reg;
    reg tick_reg;
    wire int_edge = int_osc_tick & ~clk_out_reg;
    wire ext_edge = clk_in_s & ~clk_in_d_reg;
    // pick the timing source from the select pin
    wire time_tick = osc_ext_s ? ext_edge : int_edge;

    always @(posedge sys_clk) begin
        if (rst) begin
            clk_out_reg <= 1'b0;
            clk_oe_reg <= 1'b0;
            clk_in_d_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else if (clk_en) begin
            clk_in_d_reg <= clk_in_s;
            if (int_osc_tick) begin
                clk_out_reg <= ~clk_out_reg;
            end
            // output only on internal source and only while displaying
            clk_oe_reg <= ~osc_ext_s & display_en;
            // display enable must reach all drivers together
            tick_reg <= time_tick & display_en;
        end
    end

    // ------------------------------------------------------------
    // backplane phase and alignment line
    // ------------------------------------------------------------
    reg [`LCDCS_PHASE_W-1:0] phase_reg;
    reg [`LCDCS_PHASE_W-1:0] phase_next;
    reg sync_oe_reg;
    reg sync_oe_next;
    reg [`LCDCS_CNT_W-1:0] hold_cnt_reg;
    reg [`LCDCS_CNT_W-1:0] hold_cnt_next;
    reg [`LCDCS_CNT_W-1:0] guard_cnt_reg;
    reg [`LCDCS_CNT_W-1:0] guard_cnt_next;
    reg sync_line_d_reg;
    reg realign_reg;
    reg realign_next;
    reg phase_tick_reg;

    // a low edge while we are neither driving nor just released is foreign
    wire sync_fall = sync_line_d_reg & ~sync_line_s;
    wire watching = ~sync_oe_reg && (guard_cnt_reg == `LCDCS_CNT_ZERO);
    wire foreign_assert = sync_fall & watching;
    wire [`LCDCS_PHASE_W-1:0] lp = last_phase(mux_mode);

    always @* begin
        phase_next = phase_reg;
        sync_oe_next = sync_oe_reg;
        hold_cnt_next = hold_cnt_reg;
        guard_cnt_next = guard_cnt_reg;
        realign_next = 1'b0;
        if (guard_cnt_reg != `LCDCS_CNT_ZERO) begin
            guard_cnt_next = guard_cnt_reg - `LCDCS_CNT_ONE;
        end
        if (foreign_assert) begin
            // first device to pull the line wins; jump to our last phase
            phase_next = lp;
            realign_next = 1'b1;
        end else if (tick_reg) begin
            if (phase_reg >= lp) begin
                phase_next = `LCDCS_PHASE_FIRST;
            end else begin
                phase_next = phase_reg + 2'h1;
            end
            if (phase_next == lp) begin
                // onset of the last active backplane
                sync_oe_next = 1'b1;
                hold_cnt_next = SYNC_LOW_CYC;
            end
        end
        if (sync_oe_reg && !(tick_reg && phase_next == lp)) begin
            if (hold_cnt_reg > `LCDCS_CNT_ONE) begin
                hold_cnt_next = hold_cnt_reg - `LCDCS_CNT_ONE;
            end else begin
                // release, then ignore the pull-up rise for a few cycles
                sync_oe_next = 1'b0;
                hold_cnt_next = `LCDCS_CNT_ZERO;
                guard_cnt_next = `LCDCS_RELEASE_GUARD_CYC;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            // every device leaves reset at the same first phase
            phase_reg <= `LCDCS_PHASE_FIRST;
            sync_oe_reg <= 1'b0;
            hold_cnt_reg <= `LCDCS_CNT_ZERO;
            guard_cnt_reg <= `LCDCS_CNT_ZERO;
            sync_line_d_reg <= 1'b1;
            realign_reg <= 1'b0;
            phase_tick_reg <= 1'b0;
        end else if (clk_en) begin
            phase_reg <= phase_next;
            sync_oe_reg <= sync_oe_next;
            hold_cnt_reg <= hold_cnt_next;
            guard_cnt_reg <= guard_cnt_next;
            sync_line_d_reg <= sync_line_s;
            realign_reg <= realign_next;
            phase_tick_reg <= tick_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open-drain lines only ever drive low
    reg od_low_reg;
    always @(posedge sys_clk) begin
        if (rst) begin
            od_low_reg <= 1'b0;
        end else if (clk_en) begin
            od_low_reg <= 1'b0;
        end
    end

    assign clk_pin_out = clk_out_reg;
    assign clk_pin_oe = clk_oe_reg;
    assign frame_sync_out = od_low_reg;
    assign frame_sync_oe = sync_oe_reg;
    assign ack_out_line_out = od_low_reg;
    assign ack_out_line_oe = ack_oe_reg;
    assign device_index = device_index_reg;
    assign dev_selected = dev_selected_reg;
    assign bp_phase = phase_reg;
    assign phase_tick = phase_tick_reg;
    assign realign_pulse = realign_reg;

endmodule // lcdcs_top

// ---- logic/lcdcs_regs.vh ----
// Purpose: constants shared by the cascade sync/addressing logic
// Assumes: 25 MHz sys_clk
// Notes: definitions only
`ifndef LCDCS_REGS_VH
`define LCDCS_REGS_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define LCDCS_SYS_CLK_PERIOD_NS 40
// least low time of the alignment line, in ns
`define LCDCS_SYNC_LOW_NS 100000
// least low time in whole cycles, sized to the counter: 100000 ns / 40 ns
`define LCDCS_SYNC_LOW_CYC 12'h9C4
`define LCDCS_CNT_W 12
// cycles after own release before foreign assertions are believed
`define LCDCS_RELEASE_GUARD_CYC 12'h008

// ------------------------------------------------------------
// backplane phase
// ------------------------------------------------------------
`define LCDCS_PHASE_W 2
`define LCDCS_PHASE_FIRST 2'h0
`define LCDCS_MUX_STATIC 2'h0
`define LCDCS_MUX_2BP 2'h1
`define LCDCS_MUX_3BP 2'h2
`define LCDCS_MUX_4BP 2'h3

// ------------------------------------------------------------
// synchroniser lanes
// ------------------------------------------------------------
`define LCDCS_SYNC_LANES 5
`define LCDCS_LANE_A0 0
`define LCDCS_LANE_A1 1
`define LCDCS_LANE_OSC 2
`define LCDCS_LANE_CLK 3
`define LCDCS_LANE_SYNC 4
`define LCDCS_SYNC_RST_VAL 5'h10

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LCDCS_IDX_W 3
`define LCDCS_IDX_RST 3'h0
`define LCDCS_CNT_ZERO 12'h000
`define LCDCS_CNT_ONE 12'h001

`endif

// ---- logic/lcdcs_sync2.v ----
// Purpose: two-flop synchroniser for pins from outside the sys_clk domain
// Assumes: synchronous active-high reset, clock enable freezes state
// Notes: first stage is read only by the second stage
module lcdcs_sync2 #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg meta_reg;
            reg stable_reg;
            always @(posedge sys_clk) begin
                if (rst) begin
                    meta_reg <= RST_VAL[i];
                    stable_reg <= RST_VAL[i];
                end else if (clk_en) begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule // lcdcs_sync2

// ---- dv/lcdcs_top_properties.sv ----
// Purpose: port-level checks for lcdcs_top
// Assumes: clk_en held high
// Notes: bound below
`include "lcdcs_regs.vh"
module lcdcs_chk (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire subaddr_pin_lo,
    input wire subaddr_pin_hi,
    input wire osc_sel_pin,
    input wire group_select_bit,
    input wire [`LCDCS_IDX_W-1:0] addressed_index,
    input wire display_en,
    input wire [1:0] mux_mode,
    input wire ack_req,
    input wire int_osc_tick,
    input wire clk_pin_in,
    input wire clk_pin_out,
    input wire clk_pin_oe,
    input wire frame_sync_in,
    input wire frame_sync_out,
    input wire frame_sync_oe,
    input wire ack_out_line_out,
    input wire ack_out_line_oe,
    input wire [`LCDCS_IDX_W-1:0] device_index,
    input wire dev_selected,
    input wire [`LCDCS_PHASE_W-1:0] bp_phase,
    input wire phase_tick,
    input wire realign_pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    reg [11:0] hold_reg;
    sequence s_last_entry;
        phase_tick && bp_phase == mux_mode;
    endsequence
    // ------------------------------------------------------------
    // low time of own assertion; restarts on a new last-phase entry
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst || !frame_sync_oe) hold_reg <= 12'h000;
        else if (phase_tick && bp_phase == mux_mode) hold_reg <= 12'h001;
        else hold_reg <= hold_reg + 12'h001;
    end
    a_index_group: assert property (!$past(rst) |-> device_index[2] == $past(group_select_bit)) else $error("group bit");
    a_ack_split: assert property (!$past(rst) |-> ack_out_line_oe == $past(ack_req)) else $error("ack enable");
    a_sync_on_last: assert property ($rose(frame_sync_oe) |-> s_last_entry) else $error("sync start");
    a_sync_hold_time: assert property ($fell(frame_sync_oe) |-> hold_reg == 12'h9C4) else $error("sync low time");
    a_open_drain: assert property (!frame_sync_out && !ack_out_line_out) else $error("drives high");
    a_realign_last: assert property (realign_pulse |-> bp_phase == mux_mode && !frame_sync_oe) else $error("realign");
    a_clk_source: assert property (clk_pin_oe && !$past(rst, 4) |-> $past(display_en) && !$past(osc_sel_pin, 3))
        else $error("clock pin driven");
    a_clk_toggle: assert property (!$past(rst) |-> (clk_pin_out != $past(clk_pin_out)) == $past(int_osc_tick))
        else $error("clock toggle");
    a_phase_step: assert property (phase_tick |-> bp_phase == ($past(bp_phase) == mux_mode ? 2'h0 : $past(bp_phase) + 2'h1))
        else $error("phase step");
    a_reset_aligned: assert property ($fell(rst) |-> bp_phase == 2'h0 && !frame_sync_oe) else $error("reset phase");
endmodule // lcdcs_chk
bind lcdcs_top lcdcs_chk u_lcdcs_chk (.*);

// ---- dv/lcdcs_peer_model.sv ----
// Purpose: far side: external clock source and one peer driver
// Assumes: peer shares the pulled-up alignment line
// Notes: clock stands still while not asked to run
module lcdcs_peer (
    input wire logic ext_run,
    input wire logic peer_req,
    output logic ext_clk,
    output logic sync_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ext_clk = 1'b0;
        sync_pull = 1'b0;
    end
    always begin
        wait (ext_run);
        #160 ext_clk = ~ext_clk;
    end
    // peer only ever pulls low, and for its full least low time
    always @(posedge peer_req) begin
        sync_pull = 1'b1;
        #100000 sync_pull = 1'b0;
    end
endmodule // lcdcs_peer

// ---- dv/lcdcs_tb.sv ----
// Purpose: directed bench for lcdcs_top
// Assumes: 25 MHz sys_clk
// Notes: waits are bounded
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic lo = 0, hi = 0, osc_sel = 0, grp = 0, disp = 1, ack_req = 0, tick = 0, ext_run = 0, peer_req = 0;
    logic [2:0] addr_idx = 3'h0;
    logic [1:0] mux = 2'h0;
    wire clk_out, clk_oe, sync_out, sync_oe, ack_out, ack_oe, sel, ptick, realign, ext_clk, sync_pull;
    wire [2:0] idx;
    wire [1:0] phase;
    wire clk_line = clk_oe ? clk_out : ext_clk;
    wire sync_line = (sync_oe | sync_pull) ? 1'b0 : 1'b1;
    int errors = 0;
    int cmp_count = 0;
    always #20 sys_clk = ~sys_clk;
    lcdcs_peer u_lcdcs_peer (.ext_run(ext_run), .peer_req(peer_req), .ext_clk(ext_clk), .sync_pull(sync_pull));
    lcdcs_top u_lcdcs_top (
        .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .subaddr_pin_lo(lo), .subaddr_pin_hi(hi),
        .osc_sel_pin(osc_sel), .group_select_bit(grp), .addressed_index(addr_idx), .display_en(disp),
        .mux_mode(mux), .ack_req(ack_req), .int_osc_tick(tick), .clk_pin_in(clk_line), .clk_pin_out(clk_out),
        .clk_pin_oe(clk_oe), .frame_sync_in(sync_line), .frame_sync_out(sync_out), .frame_sync_oe(sync_oe),
        .ack_out_line_out(ack_out), .ack_out_line_oe(ack_oe), .device_index(idx), .dev_selected(sel),
        .bp_phase(phase), .phase_tick(ptick), .realign_pulse(realign)
    );
    task stop_test;
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function logic pick(input int w);
        pick = (w == 0) ? realign : (w == 1) ? ptick : sync_oe;
    endfunction
    task wait_for(input int w, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(w) !== lvl) begin
            cyc(1);
            n++;
            if (n > lim) begin
                errors++;
                $display("FAIL %0t wait ran out", $time);
                stop_test();
            end
        end
    endtask
    task do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(2);
        @(posedge sys_clk);
        rst <= 1'b0;
        cyc(4);
    endtask
    // one backplane advance needs two ticks: only the clock's rising half counts
    task osc_pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            tick <= 1'b1;
            @(posedge sys_clk);
            tick <= 1'b0;
        end
        cyc(3);
    endtask
    task t_index;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            {grp, hi, lo} <= i[2:0];
            addr_idx <= i[2:0];
            ack_req <= i[0];
            cyc(5);
            chk(idx, i[11:0]);
            chk(sel, 12'h001);
            chk(ack_oe, {11'h000, i[0]});
            chk(ack_out, 12'h000);
            @(posedge sys_clk);
            addr_idx <= i[2:0] ^ 3'h4;
            cyc(2);
            chk(sel, 12'h000);
        end
    endtask
    task t_frames;
        int n;
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            mux <= m[1:0];
            do_reset();
            chk(phase, 12'h000);
            chk(sync_line, 12'h001);
            n = 0;
            while (sync_oe !== 1'b1 && n < 8) begin
                osc_pulse(2);
                n++;
            end
            chk(n[11:0], (m == 0) ? 12'h001 : m[11:0]);
            chk(phase, m[11:0]);
            chk(sync_line, 12'h000);
            chk(sync_out, 12'h000);
            chk(clk_oe, 12'h001);
            chk(clk_out, 12'h000);
            cyc(2400);
            chk(sync_oe, 12'h001);
            wait_for(2, 1'b0, 200, n);
        end
    endtask
    task t_foreign;
        int n;
        cyc(10);
        osc_pulse(2);
        chk(phase, 12'h000);
        @(posedge sys_clk);
        peer_req <= 1'b1;
        wait_for(0, 1'b1, 20, n);
        chk(phase, 12'h003);
        chk(sync_oe, 12'h000);
        @(posedge sys_clk);
        peer_req <= 1'b0;
        cyc(2600);
        chk(sync_line, 12'h001);
    endtask
    task t_ext;
        int n;
        @(posedge sys_clk);
        osc_sel <= 1'b1;
        ext_run <= 1'b1;
        cyc(5);
        chk(clk_oe, 12'h000);
        wait_for(1, 1'b1, 20, n);
        cyc(1);
        wait_for(1, 1'b1, 20, n);
        chk(n[11:0], 12'h007);
        @(posedge sys_clk);
        osc_sel <= 1'b0;
        ext_run <= 1'b0;
    endtask
    task t_off;
        logic [1:0] p;
        @(posedge sys_clk);
        disp <= 1'b0;
        cyc(5);
        chk(clk_oe, 12'h000);
        p = phase;
        osc_pulse(2);
        chk(phase, p);
    endtask
    initial begin
        do_reset();
        t_index();
        t_frames();
        t_foreign();
        t_ext();
        t_off();
        stop_test();
    end
endmodule // tb
